// file: include/usb_status_pkg.sv
// Purpose: constants, layouts and types of the usb address, bank status and pipe flag logic
// Assumes: byte-wide register port, 12-bit byte address, one clock at 25 MHz
// Notes:
// Functional notes
// - a received usb bus reset clears the address enable bit, bit 7.
// - address enable written zero: device answers at default address 0.
// - address enable written one: device answers at the programmed address field.
// - seven-bit address field in bits 6:0, cleared by a usb bus reset.
// - out transfer answered with nak sets that bank's flow error bit 1.
// - isochronous out overrun on a bank sets that bank's flow error bit.
// - in transfers never touch flow error; they set per-bank fail bits instead.
// - crc error on isochronous out data sets the bank's crc error bit 0.
// - each pipe flag clears on writing one; writing zero leaves it alone.
// - pipe stall sets flag bit 5; interrupt when its enable is one.
// - setup transfer completion sets flag bit 4; interrupt when enabled.
// - pipe error sets flag bit 3; interrupt when enabled.
// - failed transfer sets flag bit 2; interrupt when enabled.
// - double-bank pipe completing with bank 1 current sets flag bit 1.
package usb_status_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_PIPES = 8;
    localparam int NUM_BANKS = 2;
    localparam int PIPE_FLAG_W = 6;
    localparam int BANK_STAT_W = 2;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] DEV_ADDR_OFS = 12'h00A;
    localparam logic [ADDR_W-1:0] BANK_STATUS_OFS = 12'h80A;
    localparam logic [ADDR_W-1:0] BANK_STRIDE = 12'h010;
    localparam logic [ADDR_W-1:0] EP_STATE_OFS = 12'h806;
    localparam logic [ADDR_W-1:0] PIPE_FLAG_OFS = 12'h107;
    localparam logic [ADDR_W-1:0] PIPE_EN_CLR_OFS = 12'h108;
    localparam logic [ADDR_W-1:0] PIPE_EN_SET_OFS = 12'h109;
    localparam logic [ADDR_W-1:0] PIPE_STRIDE = 12'h020;

    // field positions
    localparam int ADDR_EN_BIT = 7;
    localparam int ADDR_FIELD_MSB = 6;
    localparam int FLOW_ERR_BIT = 1;
    localparam int CRC_ERR_BIT = 0;
    localparam int STALL_BIT = 5;
    localparam int SETUP_SENT_BIT = 4;
    localparam int PIPE_FAULT_BIT = 3;
    localparam int XFER_FAILED_BIT = 2;
    localparam int BANK_ONE_DONE_BIT = 1;
    localparam int BANK_ZERO_DONE_BIT = 0;

    // values after reset
    localparam logic [6:0] ADDR_FIELD_RST = 7'h00;
    localparam logic [6:0] DEFAULT_ADDRESS = 7'h00;
    localparam logic [BANK_STAT_W-1:0] BANK_STAT_RST = 2'h0;
    localparam logic [NUM_BANKS-1:0] BANK_FAIL_RST = 2'h0;
    localparam logic [PIPE_FLAG_W-1:0] PIPE_FLAG_RST = 6'h00;
    localparam logic [PIPE_FLAG_W-1:0] PIPE_EN_RST = 6'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    typedef enum logic [1:0] {
        ADDR_DEFAULT = 2'b00,
        ADDR_ASSIGNED = 2'b01
    } addr_state_t;

    typedef struct packed {
        logic out_nak;
        logic iso_overrun;
        logic iso_crc_err;
        logic in_flow_err;
    } bank_evt_t;

    typedef struct packed {
        logic stall;
        logic setup_sent;
        logic pipe_fault;
        logic xfer_failed;
        logic xfer_done;
        logic double_bank;
        logic bank_one_current;
    } pipe_evt_t;

endpackage

// file: src/pipe_flag_reg.sv
// Purpose: one host pipe's sticky interrupt flags and their enable mask
// Assumes: events are one-cycle pulses from the pipe engine
// Notes: next_irq is combinational so the top can register it without lag
`timescale 1ns/100ps
module pipe_flag_reg import usb_status_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pipe events
    input wire pipe_evt_t evt,
    // register writes
    input wire logic flag_wr,
    input wire logic en_clr_wr,
    input wire logic en_set_wr,
    input wire logic [7:0] wr_data,
    // state
    output logic [PIPE_FLAG_W-1:0] flags,
    output logic [PIPE_FLAG_W-1:0] enables,
    output logic next_irq
);

    logic [PIPE_FLAG_W-1:0] set;
    logic [PIPE_FLAG_W-1:0] wr_lo;
    logic [PIPE_FLAG_W-1:0] next_flags;
    logic [PIPE_FLAG_W-1:0] next_enables;
    logic on_bank_one;

    assign wr_lo = wr_data[PIPE_FLAG_W-1:0];
    assign on_bank_one = evt.double_bank && evt.bank_one_current;

    always_comb begin
        set = '0;
        set[STALL_BIT] = evt.stall;
        set[SETUP_SENT_BIT] = evt.setup_sent;
        set[PIPE_FAULT_BIT] = evt.pipe_fault;
        set[XFER_FAILED_BIT] = evt.xfer_failed;
        set[BANK_ONE_DONE_BIT] = evt.xfer_done && on_bank_one;
        set[BANK_ZERO_DONE_BIT] = evt.xfer_done && !on_bank_one;
    end

    // a clear in the same cycle as an event loses to the event
    always_comb begin
        next_flags = (flags & ~(flag_wr ? wr_lo : PIPE_FLAG_RST)) | set;
    end

    always_comb begin
        next_enables = enables;
        if (en_set_wr) begin
            next_enables = enables | wr_lo;
        end else if (en_clr_wr) begin
            next_enables = enables & ~wr_lo;
        end
    end

    assign next_irq = |(next_flags & next_enables);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= PIPE_FLAG_RST;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enables <= PIPE_EN_RST;
        end else begin
            enables <= next_enables;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    stall_sets_flag_a: assert property (evt.stall |=> flags[STALL_BIT])
        else $error("stall did not set its flag");
    setup_sets_flag_a: assert property (evt.setup_sent |=> flags[SETUP_SENT_BIT])
        else $error("setup completion did not set its flag");
    fault_sets_flag_a: assert property (evt.pipe_fault |=> flags[PIPE_FAULT_BIT])
        else $error("pipe error did not set its flag");
    fail_sets_flag_a: assert property (evt.xfer_failed |=> flags[XFER_FAILED_BIT])
        else $error("transfer fail did not set its flag");
    bank_one_done_a: assert property (evt.xfer_done && on_bank_one
        |=> flags[BANK_ONE_DONE_BIT] && !$past(set[BANK_ZERO_DONE_BIT]))
        else $error("bank one completion routed wrongly");
    bank_zero_done_a: assert property (evt.xfer_done && !on_bank_one
        |=> flags[BANK_ZERO_DONE_BIT])
        else $error("bank zero completion did not set its flag");
    one_clears_flag_a: assert property (flag_wr && (wr_lo & set) == '0
        |=> (flags & $past(wr_lo)) == '0)
        else $error("writing one did not clear the flag");
    zero_keeps_flag_a: assert property (flags[STALL_BIT]
        && !(flag_wr && wr_lo[STALL_BIT]) |=> flags[STALL_BIT])
        else $error("stall flag lost without a clearing write");

    stall_irq_c: cover property (evt.stall && enables[STALL_BIT] ##1 next_irq);

endmodule

// file: src/usb_addr_status_pipe_flags.sv
// Purpose: usb device address, per-bank transfer status and host pipe interrupt flags
// Assumes: event inputs are one-cycle pulses synchronous to clk; single-cycle strobes
// Notes: read data stand only in the cycle after the read strobe, zero otherwise
`timescale 1ns/100ps
module usb_addr_status_pipe_flags import usb_status_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // usb link events
    input wire logic usb_reset,
    input wire bank_evt_t [NUM_BANKS-1:0] bank_evt,
    input wire pipe_evt_t [NUM_PIPES-1:0] pipe_evt,
    // device address and interrupt
    output logic [6:0] active_address,
    output logic irq
);

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base,
                                     input logic [ADDR_W-1:0] stride,
                                     input int unsigned idx);
        logic [ADDR_W-1:0] place;
        place = base + ADDR_W'(idx) * stride;
        reg_hit = (a == place);
    endfunction

    // device address
    addr_state_t state;
    addr_state_t next_state;
    logic [6:0] addr_field;
    logic [6:0] next_field;
    logic dev_addr_wr;

    assign dev_addr_wr = wr_stb && (addr == DEV_ADDR_OFS);

    always_comb begin
        next_state = state;
        next_field = addr_field;
        if (dev_addr_wr) begin
            next_field = wr_data[ADDR_FIELD_MSB:0];
            next_state = wr_data[ADDR_EN_BIT] ? ADDR_ASSIGNED : ADDR_DEFAULT;
        end
        // bus reset outranks a software write in the same cycle
        if (usb_reset) begin
            next_field = ADDR_FIELD_RST;
            next_state = ADDR_DEFAULT;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ADDR_DEFAULT;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_field <= ADDR_FIELD_RST;
        end else begin
            addr_field <= next_field;
        end
    end

    // registered from next values so the link sees the new address at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_address <= DEFAULT_ADDRESS;
        end else begin
            unique case (next_state)
                ADDR_DEFAULT: active_address <= DEFAULT_ADDRESS;
                ADDR_ASSIGNED: active_address <= next_field;
                default: active_address <= DEFAULT_ADDRESS;
            endcase
        end
    end

    // bank status and in-direction fail bits
    logic [BANK_STAT_W-1:0] bank_status [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_fail;
    logic [NUM_BANKS-1:0] next_bank_fail;
    logic [NUM_BANKS-1:0] fail_set;
    logic ep_state_wr;

    assign ep_state_wr = wr_stb && (addr == EP_STATE_OFS);

    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            logic hit;
            logic [BANK_STAT_W-1:0] set;
            logic [BANK_STAT_W-1:0] next_status;

            assign hit = wr_stb && reg_hit(addr, BANK_STATUS_OFS, BANK_STRIDE, b);

            always_comb begin
                set = '0;
                // in traffic is kept off the flow error bit entirely
                set[FLOW_ERR_BIT] = bank_evt[b].out_nak
                                    || bank_evt[b].iso_overrun;
                set[CRC_ERR_BIT] = bank_evt[b].iso_crc_err;
                next_status = (hit ? wr_data[BANK_STAT_W-1:0] : bank_status[b]) | set;
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bank_status[b] <= BANK_STAT_RST;
                end else begin
                    bank_status[b] <= next_status;
                end
            end

            assign fail_set[b] = bank_evt[b].in_flow_err;
        end
    endgenerate

    always_comb begin
        next_bank_fail = (bank_fail & ~(ep_state_wr ? wr_data[NUM_BANKS-1:0] : BANK_FAIL_RST))
                         | fail_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_fail <= BANK_FAIL_RST;
        end else begin
            bank_fail <= next_bank_fail;
        end
    end

    // host pipe flags, one register set per pipe at a fixed stride
    logic [7:0] pipe_rd [NUM_PIPES];
    logic [NUM_PIPES-1:0] pipe_next_irq;

    genvar p;
    generate
        for (p = 0; p < NUM_PIPES; p++) begin : g_pipe
            logic flag_hit;
            logic clr_hit;
            logic set_hit;
            logic [PIPE_FLAG_W-1:0] flags;
            logic [PIPE_FLAG_W-1:0] enables;

            assign flag_hit = reg_hit(addr, PIPE_FLAG_OFS, PIPE_STRIDE, p);
            assign clr_hit = reg_hit(addr, PIPE_EN_CLR_OFS, PIPE_STRIDE, p);
            assign set_hit = reg_hit(addr, PIPE_EN_SET_OFS, PIPE_STRIDE, p);

            pipe_flag_reg u_flags (
                .clk(clk),
                .rst_n(rst_n),
                .evt(pipe_evt[p]),
                .flag_wr(wr_stb && flag_hit),
                .en_clr_wr(wr_stb && clr_hit),
                .en_set_wr(wr_stb && set_hit),
                .wr_data(wr_data),
                .flags(flags),
                .enables(enables),
                .next_irq(pipe_next_irq[p])
            );

            always_comb begin
                pipe_rd[p] = READ_IDLE;
                if (flag_hit) begin
                    pipe_rd[p] = {2'b00, flags};
                end else if (clr_hit || set_hit) begin
                    pipe_rd[p] = {2'b00, enables};
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |pipe_next_irq;
        end
    end

    // read path; unmapped addresses read as zero
    logic [7:0] next_rd;

    always_comb begin
        next_rd = READ_IDLE;
        if (addr == DEV_ADDR_OFS) begin
            next_rd = {state == ADDR_ASSIGNED, addr_field};
        end
        if (addr == EP_STATE_OFS) begin
            next_rd = {6'h00, bank_fail};
        end
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (reg_hit(addr, BANK_STATUS_OFS, BANK_STRIDE, i)) begin
                next_rd = {6'h00, bank_status[i]};
            end
        end
        for (int i = 0; i < NUM_PIPES; i++) begin
            next_rd = next_rd | pipe_rd[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= READ_IDLE;
        end else begin
            rd_data <= rd_stb ? next_rd : READ_IDLE;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    reset_drops_enable_a: assert property (usb_reset |=> state == ADDR_DEFAULT
        ##0 active_address == DEFAULT_ADDRESS)
        else $error("usb reset left the address enabled");
    reset_clears_field_a: assert property (usb_reset |=> addr_field == ADDR_FIELD_RST)
        else $error("usb reset left the address field set");
    disable_gives_zero_a: assert property (dev_addr_wr && !wr_data[ADDR_EN_BIT]
        |=> active_address == DEFAULT_ADDRESS)
        else $error("disabled address not default");
    enable_uses_field_a: assert property (dev_addr_wr && wr_data[ADDR_EN_BIT]
        && !usb_reset |=> active_address == $past(wr_data[ADDR_FIELD_MSB:0]))
        else $error("enabled address not taken from field");
    nak_sets_flow_a: assert property (bank_evt[0].out_nak
        |=> bank_status[0][FLOW_ERR_BIT])
        else $error("out nak did not set flow error");
    overrun_sets_flow_a: assert property (bank_evt[1].iso_overrun
        |=> bank_status[1][FLOW_ERR_BIT])
        else $error("iso overrun did not set flow error");
    in_fail_routed_a: assert property (bank_evt[0].in_flow_err && !bank_evt[0].out_nak
        && !bank_evt[0].iso_overrun && !wr_stb
        |=> bank_fail[0] && bank_status[0][FLOW_ERR_BIT] == $past(bank_status[0][FLOW_ERR_BIT]))
        else $error("in flow error misrouted");
    crc_sets_bit_a: assert property (bank_evt[0].iso_crc_err
        |=> bank_status[0][CRC_ERR_BIT])
        else $error("iso crc error not recorded");
    irq_follows_flags_a: assert property (pipe_evt[0].stall
        && g_pipe[0].enables[STALL_BIT] && !wr_stb |=> irq)
        else $error("enabled stall raised no interrupt");
    read_one_cycle_a: assert property (!rd_stb |=> rd_data == READ_IDLE)
        else $error("read data outside read cycle");

    addr_assign_c: cover property (dev_addr_wr && wr_data[ADDR_EN_BIT] ##1 state == ADDR_ASSIGNED);
    reset_after_assign_c: cover property (state == ADDR_ASSIGNED && usb_reset);
    crc_seen_c: cover property (bank_evt[1].iso_crc_err);
    pipe_irq_c: cover property (!irq ##1 irq);

endmodule

// file: verification/usb_bus_partner.sv
// Purpose: far-side usb partner producing link events toward the block
// Assumes: events are one-cycle pulses launched right after a rising edge
// Notes: qualifier levels travel inside the pulse and drop with it
`timescale 1ns/100ps
module usb_bus_partner import usb_status_pkg::*; (
    // clock
    input wire logic clk,
    // link events toward the block
    output logic usb_reset,
    output bank_evt_t [NUM_BANKS-1:0] bank_evt,
    output pipe_evt_t [NUM_PIPES-1:0] pipe_evt
);
    initial begin
        usb_reset = 1'b0;
        bank_evt = '0;
        pipe_evt = '0;
    end

    task automatic bus_reset();
        @(posedge clk);
        usb_reset <= 1'b1;
        @(posedge clk);
        usb_reset <= 1'b0;
    endtask

    task automatic bank_event(input int b, input bank_evt_t e);
        @(posedge clk);
        bank_evt[b] <= e;
        @(posedge clk);
        bank_evt[b] <= '0;
    endtask

    // bank select levels only mean something beside xfer_done
    task automatic pipe_event(input int p, input pipe_evt_t e);
        @(posedge clk);
        pipe_evt[p] <= e;
        @(posedge clk);
        pipe_evt[p] <= '0;
    endtask
endmodule

// file: verification/test_usb_addr_status_pipe_flags.sv
// Purpose: self-checking bench for address, bank status and pipe flag logic
// Assumes: partner model drives all link events
// Notes: register addresses taken from the package offsets; expected values written as literals
`timescale 1ns/100ps
module test_usb_addr_status_pipe_flags import usb_status_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rd_data;
    logic usb_reset;
    bank_evt_t [NUM_BANKS-1:0] bank_evt;
    pipe_evt_t [NUM_PIPES-1:0] pipe_evt;
    logic [6:0] active_address;
    logic irq;
    int errors = 0;
    int n_tests = 0;

    usb_addr_status_pipe_flags dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .usb_reset(usb_reset), .bank_evt(bank_evt), .pipe_evt(pipe_evt),
        .active_address(active_address), .irq(irq));
    usb_bus_partner partner_u (.clk(clk), .usb_reset(usb_reset), .bank_evt(bank_evt),
        .pipe_evt(pipe_evt));

    always #20 clk = ~clk;

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        check8(rd_data, exp, "read data");
    endtask

    function automatic logic [ADDR_W-1:0] pipe_reg(input int p, input logic [ADDR_W-1:0] ofs);
        return ADDR_W'(ofs + PIPE_STRIDE * p);
    endfunction

    task automatic test_reset_values();
        check8({1'b0, active_address}, 8'h00, "address after reset");
        check1(irq, 1'b0, "irq after reset");
        rd_chk(DEV_ADDR_OFS, 8'h00);
        for (int p = 0; p < NUM_PIPES; p++) begin
            rd_chk(pipe_reg(p, PIPE_FLAG_OFS), 8'h00);
        end
        rd_chk(12'h7F0, READ_IDLE);
        @(posedge clk);
        #1;
        check8(rd_data, READ_IDLE, "read data after its cycle");
        $display("test reset_values done");
    endtask

    task automatic test_address();
        reg_wr(DEV_ADDR_OFS, 8'h85);
        check8({1'b0, active_address}, 8'h05, "enabled address");
        rd_chk(DEV_ADDR_OFS, 8'h85);
        reg_wr(DEV_ADDR_OFS, 8'h05);
        check8({1'b0, active_address}, 8'h00, "disabled address");
        reg_wr(DEV_ADDR_OFS, 8'hFF);
        check8({1'b0, active_address}, 8'h7F, "top address");
        partner_u.bus_reset();
        #1;
        check8({1'b0, active_address}, 8'h00, "address after bus reset");
        rd_chk(DEV_ADDR_OFS, 8'h00);
        // bus reset on the same edge as an enabling write must win
        fork
            reg_wr(DEV_ADDR_OFS, 8'h85);
            partner_u.bus_reset();
        join
        check8({1'b0, active_address}, 8'h00, "reset beside write");
        rd_chk(DEV_ADDR_OFS, 8'h00);
        $display("test address done");
    endtask

    task automatic test_bank_status();
        logic [ADDR_W-1:0] b1;
        b1 = BANK_STATUS_OFS + BANK_STRIDE;
        reg_wr(BANK_STATUS_OFS, 8'h03);
        rd_chk(BANK_STATUS_OFS, 8'h03);
        reg_wr(BANK_STATUS_OFS, 8'h00);
        partner_u.bank_event(0, 4'b1000);
        rd_chk(BANK_STATUS_OFS, 8'h02);
        partner_u.bank_event(1, 4'b0100);
        rd_chk(b1, 8'h02);
        partner_u.bank_event(0, 4'b0010);
        rd_chk(BANK_STATUS_OFS, 8'h03);
        reg_wr(b1, 8'h00);
        partner_u.bank_event(1, 4'b0001);
        rd_chk(b1, 8'h00);
        rd_chk(EP_STATE_OFS, 8'h02);
        reg_wr(EP_STATE_OFS, 8'h02);
        rd_chk(EP_STATE_OFS, 8'h00);
        $display("test bank_status done");
    endtask

    // event encodings: stall setup fault failed done double bank_one
    task automatic test_pipe_flags(input int p);
        logic [6:0] evs [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h06, 7'h07};
        logic [7:0] exps [7] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h01, 8'h02};
        reg_wr(pipe_reg(p, PIPE_EN_SET_OFS), 8'h3F);
        rd_chk(pipe_reg(p, PIPE_EN_CLR_OFS), 8'h3F);
        for (int k = 0; k < 7; k++) begin
            partner_u.pipe_event(p, evs[k]);
            #1;
            check1(irq, 1'b1, "irq on enabled flag");
            rd_chk(pipe_reg(p, PIPE_FLAG_OFS), exps[k]);
            reg_wr(pipe_reg(p, PIPE_FLAG_OFS), ~exps[k] & 8'h3F);
            rd_chk(pipe_reg(p, PIPE_FLAG_OFS), exps[k]);
            reg_wr(pipe_reg(p, PIPE_FLAG_OFS), exps[k]);
            check1(irq, 1'b0, "irq after clear");
            rd_chk(pipe_reg(p, PIPE_FLAG_OFS), 8'h00);
        end
        reg_wr(pipe_reg(p, PIPE_EN_CLR_OFS), 8'h3F);
        partner_u.pipe_event(p, 7'h40);
        #1;
        check1(irq, 1'b0, "masked stall");
        rd_chk(pipe_reg(p, PIPE_FLAG_OFS), 8'h20);
        reg_wr(pipe_reg(p, PIPE_EN_SET_OFS), 8'h20);
        check1(irq, 1'b1, "stall unmasked");
        reg_wr(pipe_reg(p, PIPE_FLAG_OFS), 8'h20);
        reg_wr(pipe_reg(p, PIPE_EN_CLR_OFS), 8'h3F);
        check1(irq, 1'b0, "irq idle");
        // clearing write on the same edge as a stall: the stall wins
        fork
            reg_wr(pipe_reg(p, PIPE_FLAG_OFS), 8'h20);
            partner_u.pipe_event(p, 7'h40);
        join
        rd_chk(pipe_reg(p, PIPE_FLAG_OFS), 8'h20);
        reg_wr(pipe_reg(p, PIPE_FLAG_OFS), 8'h20);
        rd_chk(pipe_reg(p, PIPE_FLAG_OFS), 8'h00);
        $display("test pipe_flags %0d done", p);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_reset_values();
        test_address();
        test_bank_status();
        test_pipe_flags(0);
        test_pipe_flags(NUM_PIPES - 1);
        results();
    end

    // run needs about three hundred cycles
    initial begin
        #200000;
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end
endmodule
